// File: core/fast_pcs_pkg.sv
// constants and carriers for the fast pcs configuration and status register
package fast_pcs_pkg;

	// register placement: index as printed, byte address four times it
	localparam logic [7:0]  PCS_CFG_INDEX = 8'h16;
	localparam logic [7:0]  PCS_CFG_ADDR  = 8'h58;
	localparam int          ADDR_WIDTH    = 8;
	localparam int          DATA_WIDTH    = 32;

	// field positions
	localparam int          BIT_QUIET     = 10;
	localparam int          BIT_SD_FORCE  = 9;
	localparam int          BIT_SD_ALGO   = 8;
	localparam int          BIT_DESCRAMBLER_TIMEOUT_SELECT = 7;
	localparam int          BIT_FORCE_OK  = 5;
	localparam int          BIT_BYPASS    = 2;

	// writable bits and reset value of the 16-bit register
	localparam logic [15:0] PCS_CFG_MASK  = 16'h0_7A4;
	localparam logic [15:0] PCS_CFG_RESET = 16'h0_100;

	// descrambler timeouts and clock period
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          DESC_SHORT_NS  = 722000;
	localparam int          DESC_LONG_NS   = 2000000;
	localparam int          DESC_SHORT_CYC = DESC_SHORT_NS / CLK_PERIOD_NS;
	localparam int          DESC_LONG_CYC  = DESC_LONG_NS / CLK_PERIOD_NS;
	localparam int          TIMEOUT_WIDTH  = 15;

	// control fields that steer the 100 Mb/s path
	typedef struct packed {
		logic quiet_transmit_enable;
		logic signal_detect_force;
		logic signal_detect_algorithm_select;
		logic descrambler_timeout_select;
		logic force_good_link;
		logic nrzi_bypass;
	} pcs_ctrl_s;

	// wishbone request from the master
	typedef struct packed {
		logic                  cyc;
		logic                  stb;
		logic                  we;
		logic [3:0]            sel;
		logic [ADDR_WIDTH-1:0] adr;
		logic [DATA_WIDTH-1:0] dat;
	} wb_req_s;

endpackage

// File: core/fast_pcs_config_status_reg.sv
// fast pcs configuration and status register with a wishbone slave
//
// Function
// - bits 15 to 13 always read as zero and writes to them are dropped.
// - bit 10 resets to zero, is read-write and turns on quiet transmit mode.
// - bit 9 resets to zero, is read-write and forces signal detect.
// - bit 8 resets to one, is read-write and picks the enhanced detect algorithm.
// - bit 7 resets to zero, is read-write and stretches the descrambler timeout to 2 ms.
// - bit 5 resets to zero, is read-write and forces a good 100 Mb/s link.
// - bit 2 resets to zero, is read-write and bypasses NRZI coding.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ns
module fast_pcs_config_status_reg
	import fast_pcs_pkg::*;
#(
	parameter int SHORT_CYCLES = DESC_SHORT_CYC,
	parameter int LONG_CYCLES  = DESC_LONG_CYC
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// wishbone slave
	input  wire wb_req_s                  wb_req_i,
	output logic                          ack_o,
	output logic     [DATA_WIDTH-1:0]     dat_o,
	// controls to the 100 Mb/s path
	output pcs_ctrl_s                     ctrl_o,
	output logic     [TIMEOUT_WIDTH-1:0]  desc_timeout_cycles_o
);

	typedef struct packed {
		logic                     ack;
		logic [DATA_WIDTH-1:0]    dat;
		logic [15:0]              cfg;
		logic [TIMEOUT_WIDTH-1:0] timeout;
	} state_s;

	state_s state;
	state_s next_state;
	logic   hit;
	logic   wr_now;

	// address decode used for read and write
	function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] adr);
		return adr == PCS_CFG_ADDR;
	endfunction

	// bus decode: write lands on the edge where ack is seen high
	assign hit    = addr_hit(wb_req_i.adr);
	assign wr_now = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && state.ack && hit;

	// next state
	always_comb begin
		next_state     = state;
		next_state.ack = wb_req_i.cyc && wb_req_i.stb && !state.ack;
		next_state.dat = '0;
		// reserved top bits read zero
		// data is loaded only for the answer cycle, so dat_o idles at zero
		if (hit && wb_req_i.cyc && wb_req_i.stb && !state.ack)
			next_state.dat = {16'h0_000, state.cfg & PCS_CFG_MASK};
		if (wr_now) begin
			// writable fields only, per byte lane
			if (wb_req_i.sel[0])
				next_state.cfg[7:0] = wb_req_i.dat[7:0] & PCS_CFG_MASK[7:0];
			if (wb_req_i.sel[1])
				next_state.cfg[15:8] = wb_req_i.dat[15:8] & PCS_CFG_MASK[15:8];
		end
		// timeout length follows the select bit
		next_state.timeout = state.cfg[BIT_DESCRAMBLER_TIMEOUT_SELECT] ? TIMEOUT_WIDTH'(LONG_CYCLES)
			: TIMEOUT_WIDTH'(SHORT_CYCLES);
		if (rst_i) begin
			next_state.ack     = 1'b0;
			next_state.dat     = '0;
			next_state.cfg     = PCS_CFG_RESET;
			next_state.timeout = TIMEOUT_WIDTH'(SHORT_CYCLES);
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	// outputs straight from state flops
	assign ack_o                 = state.ack;
	assign dat_o                 = state.dat;
	assign desc_timeout_cycles_o = state.timeout;
	assign ctrl_o.quiet_transmit_enable          = state.cfg[BIT_QUIET];
	assign ctrl_o.signal_detect_force            = state.cfg[BIT_SD_FORCE];
	assign ctrl_o.signal_detect_algorithm_select = state.cfg[BIT_SD_ALGO];
	assign ctrl_o.descrambler_timeout_select     = state.cfg[BIT_DESCRAMBLER_TIMEOUT_SELECT];
	assign ctrl_o.force_good_link                = state.cfg[BIT_FORCE_OK];
	assign ctrl_o.nrzi_bypass                    = state.cfg[BIT_BYPASS];

	// read data never shows reserved top bits
	reserved_zero_a: assert property (
		@(posedge clk_i) disable iff (rst_i) dat_o[31:13] == '0)
		else $error("reserved bits read nonzero");

	quiet_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[1]
		|=> ctrl_o.quiet_transmit_enable == $past(wb_req_i.dat[BIT_QUIET]))
		else $error("quiet enable not written");

	sd_force_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.signal_detect_force))
		else $error("signal detect force changed without write");

	algo_reset_a: assert property (
		@(posedge clk_i) $fell(rst_i) |-> ctrl_o.signal_detect_algorithm_select
		&& !ctrl_o.quiet_transmit_enable && !ctrl_o.nrzi_bypass)
		else $error("wrong reset value");

	timeout_len_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ctrl_o.descrambler_timeout_select [*2]
		|-> desc_timeout_cycles_o == TIMEOUT_WIDTH'(LONG_CYCLES))
		else $error("timeout length wrong");

	force_link_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[0]
		|=> ctrl_o.force_good_link == $past(wb_req_i.dat[BIT_FORCE_OK]))
		else $error("force link not written");

	bypass_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ack_o && hit && !$past(rst_i)
		|-> dat_o[BIT_BYPASS] == $past(ctrl_o.nrzi_bypass))
		else $error("bypass readback wrong");

	ack_pulse_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
		else $error("ack longer than one cycle");

	// every new request is answered on the following edge
	ack_timing_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wb_req_i.cyc && wb_req_i.stb && !ack_o
		|=> ack_o)
		else $error("ack not given one cycle after request");

	// read data is zero outside the answer cycle
	idle_data_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == '0)
		else $error("read data not zero while idle");

	// an unmapped address always reads back zero
	unmapped_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ack_o && !hit |-> dat_o == '0)
		else $error("unmapped read not zero");

	// reserved positions are never stored
	reserved_store_a: assert property (
		@(posedge clk_i) disable iff (rst_i) (state.cfg & ~PCS_CFG_MASK) == 16'h0000)
		else $error("reserved bit stored");

	// quiet enable reads back what is stored
	quiet_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ack_o && hit && !$past(rst_i)
		|-> dat_o[BIT_QUIET] == $past(ctrl_o.quiet_transmit_enable))
		else $error("quiet enable readback wrong");

	// quiet enable only moves on a write
	quiet_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.quiet_transmit_enable))
		else $error("quiet enable changed without write");

	// signal detect force takes the written bit
	sd_force_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[1]
		|=> ctrl_o.signal_detect_force == $past(wb_req_i.dat[BIT_SD_FORCE]))
		else $error("signal detect force not written");

	// algorithm select takes the written bit
	algo_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[1]
		|=> ctrl_o.signal_detect_algorithm_select == $past(wb_req_i.dat[BIT_SD_ALGO]))
		else $error("algorithm select not written");

	// algorithm select only moves on a write
	algo_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.signal_detect_algorithm_select))
		else $error("algorithm select changed without write");

	// timeout select takes the written bit
	desc_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[0]
		|=> ctrl_o.descrambler_timeout_select == $past(wb_req_i.dat[BIT_DESCRAMBLER_TIMEOUT_SELECT]))
		else $error("timeout select not written");

	// timeout select only moves on a write
	desc_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.descrambler_timeout_select))
		else $error("timeout select changed without write");

	// a clear select gives the short timeout
	timeout_short_a: assert property (
		@(posedge clk_i) disable iff (rst_i) (!ctrl_o.descrambler_timeout_select) [*2]
		|-> desc_timeout_cycles_o == TIMEOUT_WIDTH'(SHORT_CYCLES))
		else $error("short timeout length wrong");

	// forced link only moves on a write
	link_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.force_good_link))
		else $error("force link changed without write");

	// coding bypass takes the written bit
	bypass_write_a: assert property (
		@(posedge clk_i) disable iff (rst_i) wr_now && wb_req_i.sel[0]
		|=> ctrl_o.nrzi_bypass == $past(wb_req_i.dat[BIT_BYPASS]))
		else $error("bypass not written");

	// coding bypass only moves on a write
	bypass_hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i) !wr_now
		|=> $stable(ctrl_o.nrzi_bypass))
		else $error("bypass changed without write");

	// force signal detect reads back what is stored
	sd_force_read_a: assert property (
		@(posedge clk_i) disable iff (rst_i) ack_o && hit && !$past(rst_i)
		|-> dat_o[BIT_SD_FORCE] == $past(ctrl_o.signal_detect_force))
		else $error("signal detect force readback wrong");

endmodule

// File: test/fast_pcs_config_status_reg_bench.sv
// self-checking bench for the fast pcs configuration and status register
`timescale 1ns/1ns
module fast_pcs_config_status_reg_bench;
	import fast_pcs_pkg::*;
	logic                     clk_i = 0;
	logic                     rst_i = 1;
	wb_req_s                  wb_req_i = '0;
	logic                     ack_o;
	logic [DATA_WIDTH-1:0]    dat_o;
	pcs_ctrl_s                ctrl_o;
	logic [TIMEOUT_WIDTH-1:0] desc_timeout_cycles_o;
	int                       err_total = 0;
	int                       num_checks = 0;
	logic [31:0]              rd;
	logic [15:0]              model;
	logic [15:0]              w;
	logic [15:0]              m;
	logic [3:0]               s;
	fast_pcs_config_status_reg #(.SHORT_CYCLES(7), .LONG_CYCLES(20)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_req_i(wb_req_i), .ack_o(ack_o), .dat_o(dat_o), .ctrl_o(ctrl_o),
		.desc_timeout_cycles_o(desc_timeout_cycles_o));
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	function automatic pcs_ctrl_s exp_ctrl(input logic [15:0] v);
		return '{v[10], v[9], v[8], v[7], v[5], v[2]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wb_req_i <= '{1'b1, 1'b1, we, s, a, {16'h0, d}};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		wb_req_i <= '0;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// guard against a missing ack
	initial begin
		#500000;
		err_total++;
		finish_test();
	end
	// main sequence: reset, then random and corner writes with read-back
	initial begin
		void'($urandom(64));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		model = PCS_CFG_RESET;
		for (int i = 0; i < 60; i++) begin
			s = 4'hF;
			wb(1'b0, PCS_CFG_ADDR, 16'h0);
			chk(rd, {16'h0, model});
			chk({26'h0, ctrl_o}, {26'h0, exp_ctrl(model)});
			chk({17'h0, desc_timeout_cycles_o}, model[7] ? 32'h14 : 32'h7);
			// reserved low bits kept clear by software
			w = (i == 0) ? 16'hE7A4 : (i == 1) ? 16'h0 : 16'($urandom) & 16'hE7A4;
			s = (i < 2) ? 4'h3 : 4'($urandom);
			if (i % 5 == 4) begin
				wb(1'b1, 8'h5C, w);
				wb(1'b0, 8'h5C, 16'h0);
				chk(rd, 32'h0);
			end else begin
				wb(1'b1, PCS_CFG_ADDR, w);
				m = {{8{s[1]}}, {8{s[0]}}};
				model = ((model & ~m) | (w & m)) & PCS_CFG_MASK;
			end
			if (i == 30) begin
				rst_i <= 1'b1;
				repeat (2) @(posedge clk_i);
				rst_i <= 1'b0;
				model = PCS_CFG_RESET;
			end
		end
		finish_test();
	end
endmodule
